// ### core/power_mode_pkg.sv
/*
 * Shared constants and types for the power-mode clock sequencer.
 * Assumes a 40 MHz register clock and byte addresses on the bus.
 */
package power_mode_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int          ADDR_W     = 4;
   localparam logic [3:0]  REG_CTRL   = 4'h0;
   localparam logic [3:0]  REG_CONFIG = 4'h4;
   localparam logic [3:0]  REG_STATUS = 4'h8;

   // Control fields.
   localparam int SEL_LO_BIT = 0;
   localparam int SEL_HI_BIT = 1;
   localparam int LFSS_BIT   = 3;
   localparam int FREQ_LSB   = 4;
   localparam int FREQ_W     = 3;
   localparam int IDLE_BIT   = 7;

   // Configuration fields.
   localparam int SEC_EN_BIT   = 0;
   localparam int WDT_EN_BIT   = 1;
   localparam int FAIL_MON_BIT = 2;
   localparam int TWO_SPD_BIT  = 3;

   // Status fields.
   localparam int PRI_FLAG_BIT = 0;
   localparam int INT_FLAG_BIT = 1;
   localparam int SEC_FLAG_BIT = 2;
   localparam int MODE_LSB     = 4;
   localparam int CPU_RUN_BIT  = 7;

   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [3:0] CONFIG_RESET = 4'h0;

   // Mode codes shown in status.
   localparam logic [2:0] CODE_PRIMARY_RUN_MODE  = 3'h0;
   localparam logic [2:0] CODE_SECONDARY_RUN_MODE  = 3'h1;
   localparam logic [2:0] CODE_INT_RUN  = 3'h2;
   localparam logic [2:0] CODE_SLEEP    = 3'h3;
   localparam logic [2:0] CODE_PRIMARY_IDLE_MODE = 3'h4;
   localparam logic [2:0] CODE_SECONDARY_IDLE_MODE = 3'h5;
   localparam logic [2:0] CODE_INT_IDLE = 3'h6;
   localparam logic [2:0] CODE_WAKING   = 3'h7;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ       = 40;
   localparam int CPU_READY_NS  = 2000;
   localparam int SETTLE_NS     = 1000;
   localparam int CPU_READY_CYC = (CPU_READY_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_CYC    = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W         = 8;
   localparam int SYNC_W        = 2;

   typedef enum logic [2:0] {
      M_RUN, M_SLEEP, M_IDLE, M_WAKE, M_READY
   } mode_type;

   typedef enum logic [1:0] {
      SRC_NONE, SRC_PRI, SRC_SEC, SRC_INT
   } src_type;

endpackage

// ### core/osc_sync_if.sv
/*
 * Carries oscillator status pins into the sequencer after filtering.
 * Assumes both ends share the register clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface osc_sync_if;
   import power_mode_pkg::*;
   logic [SYNC_W-1:0] raw;
   logic [SYNC_W-1:0] clean;
   modport filter (input raw, output clean);
   modport user   (output raw, input clean);
endinterface
`default_nettype wire

// ### core/osc_sync.sv
/*
 * Three-stage synchroniser for oscillator status pins.
 * Assumes the pins are asynchronous to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module osc_sync
   import power_mode_pkg::*;
(
   input  wire logic   clk_in,    // Register clock
   input  wire logic   arst_n_in, // Asynchronous reset, active low
   osc_sync_if.filter  sync_io    // Raw pins in, filtered levels out
);

   typedef struct packed {
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
      logic [SYNC_W-1:0] s3;
      logic [SYNC_W-1:0] q;
   } sync_state_type;

   sync_state_type st_r;
   sync_state_type st_nxt;

   // A bit changes only once stages two and three agree.
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = sync_io.raw;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int i = 0; i < SYNC_W; i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.q[i] = st_r.s3[i];
         end
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_io.clean = st_r.q;

endmodule // osc_sync
`default_nettype wire

// ### core/power_mode_clock_sequencer.sv
/*
 * Power-mode clock sequencer: picks the clock source for CPU and
 * peripherals, runs Sleep and Idle entry and wake, keeps status flags.
 * Assumes sleep and wake strobes come from logic on clk_in and that
 * oscillator-ready pins are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Select-high set: go internal, primary off
// - Select-low ignored while select-high set
// - Frequency field writes take effect at once
// - Zero frequency and source: slow RC clocks
// - Stable flag set only after settling
// - Already-stable fast oscillator keeps flag set
// - Internal to primary: switch when primary ready
// - Clock switch leaves control bits unchanged
// - Slow RC runs if watchdog/monitor enabled
// - Sleep: clocks stop, all status flags clear
// - Sleep/Idle: secondary keeps running; slow RC in Sleep only with watchdog/monitor
// - Sleep wake waits source unless two-speed or fail monitor
// - Idle: CPU stops, peripherals clocked, flags kept
// - Idle exits by wake event, then ready delay
// - Wake never alters control bits
// - Watchdog in Sleep/Idle wakes, not resets
// - Primary idle keeps primary and its flag
// - Primary idle wake: primary after delay
// - Secondary idle: primary off, secondary flag
// - Secondary idle wake stays on secondary
// - Secondary disabled: secondary-idle sleep ignored
// - Secondary not running: peripherals withheld
// - Select pair 00 pri, 01 sec, 1x internal
// - Idle bit sampled when sleep executes
module power_mode_clock_sequencer
   import power_mode_pkg::*;
(
   input  wire logic         clk_in,                  // Register clock
   input  wire logic         arst_n_in,               // Reset, active low
   input  wire logic [3:0]   avs_address_in,          // Byte address
   input  wire logic         avs_read_in,             // Read request
   input  wire logic         avs_write_in,            // Write request
   input  wire logic [31:0]  avs_writedata_in,        // Write data
   input  wire logic [3:0]   avs_byteenable_in,       // Byte lanes
   output logic [31:0]       avs_readdata_out,        // Read data
   output logic              avs_waitrequest_out,     // Stall
   input  wire logic         sleep_exec_in,           // Sleep executed
   input  wire logic         wake_irq_in,             // Interrupt wake
   input  wire logic         wdt_timeout_in,          // Watchdog time-out
   input  wire logic         primary_ready_in,        // Primary ready pin
   input  wire logic         secondary_running_in,    // Secondary running
   output logic              cpu_clk_en_out,          // CPU clock gate
   output logic              periph_clk_en_out,       // Peripheral gate
   output logic [1:0]        clock_mux_sel_out,       // Source select
   output logic [2:0]        internal_freq_out,       // Internal divider
   output logic              primary_osc_en_out,      // Primary on
   output logic              secondary_osc_en_out,    // Secondary on
   output logic              fast_internal_osc_en_out,// Fast osc on
   output logic              slow_internal_rc_en_out, // Slow RC on
   output logic              wdt_reset_out            // Watchdog reset
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      mode_type          mode;
      src_type           src;
      logic              idle_on_sleep;
      logic              clock_select_hi;
      logic              clock_select_lo;
      logic              low_freq_source_select;
      logic [FREQ_W-1:0] internal_freq_select;
      logic              secondary_osc_enable;
      logic              wdt_en;
      logic              fail_mon_en;
      logic              two_speed_en;
      logic [CNT_W-1:0]  settle_cnt;
      logic              settled;
      logic [CNT_W-1:0]  dly_cnt;
      logic              ack;
      logic [31:0]       rdata;
      logic              wdt_rst;
   } seq_state_type;

   seq_state_type st_r;
   seq_state_type st_nxt;

   localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);
   localparam logic [CNT_W-1:0] READY_LAST  = CNT_W'(CPU_READY_CYC - 1);

   osc_sync_if sync_io ();

   logic pri_ready;
   logic sec_running;

   assign sync_io.raw = {secondary_running_in, primary_ready_in};
   assign pri_ready   = sync_io.clean[0];
   assign sec_running = sync_io.clean[1];

   osc_sync u_osc_sync (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .sync_io   (sync_io)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic src_ok(input seq_state_type s, input src_type c,
                                   input logic pr, input logic sr);
      case (c)
         SRC_PRI: src_ok = pr;
         SRC_SEC: src_ok = s.secondary_osc_enable && sr;
         SRC_INT: src_ok = 1'b1;
         default: src_ok = 1'b0;
      endcase
   endfunction

   function automatic logic [1:0] mux_code(input src_type c);
      case (c)
         SRC_PRI: mux_code = 2'h0;
         SRC_SEC: mux_code = 2'h1;
         SRC_INT: mux_code = 2'h2;
         default: mux_code = 2'h3;
      endcase
   endfunction

   function automatic logic [2:0] mode_code(input seq_state_type s);
      logic [2:0] base;
      base = 3'h0;
      case (s.src)
         SRC_SEC: base = CODE_SECONDARY_RUN_MODE;
         SRC_INT: base = CODE_INT_RUN;
         default: base = CODE_PRIMARY_RUN_MODE;
      endcase
      case (s.mode)
         M_RUN:   mode_code = base;
         M_IDLE:  mode_code = base | CODE_PRIMARY_IDLE_MODE;
         M_SLEEP: mode_code = CODE_SLEEP;
         default: mode_code = CODE_WAKING;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Derived terms
   // ----------------------------------------------------------------
   src_type target;
   logic    fast_req;
   logic    wake;
   logic    bus_req;
   logic    bus_take;

   always_comb begin
      if (st_r.clock_select_hi) begin
         target = SRC_INT;
      end else if (st_r.clock_select_lo) begin
         target = SRC_SEC;
      end else begin
         target = SRC_PRI;
      end
   end

   assign fast_req = (st_r.internal_freq_select != '0) || st_r.low_freq_source_select;
   assign wake     = wake_irq_in || wdt_timeout_in;
   assign bus_req  = avs_read_in || avs_write_in;
   assign bus_take = bus_req && st_r.ack;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt         = st_r;
      st_nxt.wdt_rst = 1'b0;

      // Fast oscillator settling runs in every mode but Sleep, so a source
      // that was already stable keeps its flag across a switch.
      if (!fast_req || st_r.mode == M_SLEEP) begin
         st_nxt.settle_cnt = '0;
         st_nxt.settled    = 1'b0;
      end else if (!st_r.settled) begin
         if (st_r.settle_cnt == SETTLE_LAST) begin
            st_nxt.settled = 1'b1;
         end else begin
            st_nxt.settle_cnt = st_r.settle_cnt + 1'b1;
         end
      end

      case (st_r.mode)
         M_RUN: begin
            // Old source keeps clocking until the new one is ready.
            if (st_r.src != target &&
                src_ok(st_r, target, pri_ready, sec_running)) begin
               st_nxt.src = target;
            end
            if (wdt_timeout_in) begin
               st_nxt.wdt_rst = 1'b1;
            end
            if (sleep_exec_in) begin
               if (!st_r.idle_on_sleep) begin
                  st_nxt.mode = M_SLEEP;
                  st_nxt.src  = SRC_NONE;
               end else if (target == SRC_SEC &&
                            !st_r.secondary_osc_enable) begin
                  st_nxt.mode = M_RUN;
               end else begin
                  st_nxt.mode = M_IDLE;
                  if (target == SRC_SEC) begin
                     st_nxt.src = SRC_SEC;
                  end
               end
            end
         end

         M_IDLE: begin
            if (st_r.src != target &&
                src_ok(st_r, target, pri_ready, sec_running)) begin
               st_nxt.src = target;
            end
            if (wake) begin
               st_nxt.mode    = M_READY;
               st_nxt.dly_cnt = '0;
            end
         end

         M_SLEEP: begin
            if (wake) begin
               st_nxt.mode = M_WAKE;
            end
         end

         M_WAKE: begin
            if (src_ok(st_r, target, pri_ready, sec_running)) begin
               st_nxt.src     = target;
               st_nxt.mode    = M_READY;
               st_nxt.dly_cnt = '0;
            end else if (st_r.two_speed_en || st_r.fail_mon_en) begin
               // Run early from the internal block; the run-mode switch
               // moves to the chosen source once it is ready.
               st_nxt.src     = SRC_INT;
               st_nxt.mode    = M_READY;
               st_nxt.dly_cnt = '0;
            end
         end

         M_READY: begin
            if (st_r.dly_cnt == READY_LAST) begin
               st_nxt.mode = M_RUN;
            end else begin
               st_nxt.dly_cnt = st_r.dly_cnt + 1'b1;
            end
         end

         default: begin
            st_nxt.mode = M_WAKE;
            st_nxt.src  = SRC_NONE;
         end
      endcase

      // Bus slave: one wait state, then the access completes.
      st_nxt.ack = bus_req && !st_r.ack;
      if (bus_req && !st_r.ack && avs_read_in) begin
         st_nxt.rdata = '0;
         case (avs_address_in)
            REG_CTRL: begin
               st_nxt.rdata[IDLE_BIT]   = st_r.idle_on_sleep;
               st_nxt.rdata[SEL_HI_BIT] = st_r.clock_select_hi;
               st_nxt.rdata[SEL_LO_BIT] = st_r.clock_select_lo;
               st_nxt.rdata[LFSS_BIT]   = st_r.low_freq_source_select;
               st_nxt.rdata[FREQ_LSB +: FREQ_W] = st_r.internal_freq_select;
            end
            REG_CONFIG: begin
               st_nxt.rdata[SEC_EN_BIT]   = st_r.secondary_osc_enable;
               st_nxt.rdata[WDT_EN_BIT]   = st_r.wdt_en;
               st_nxt.rdata[FAIL_MON_BIT] = st_r.fail_mon_en;
               st_nxt.rdata[TWO_SPD_BIT]  = st_r.two_speed_en;
            end
            REG_STATUS: begin
               st_nxt.rdata[PRI_FLAG_BIT] = (st_r.src == SRC_PRI);
               st_nxt.rdata[SEC_FLAG_BIT] = (st_r.src == SRC_SEC);
               st_nxt.rdata[INT_FLAG_BIT] = (st_r.src == SRC_INT) &&
                                            st_r.settled;
               st_nxt.rdata[MODE_LSB +: 3] = mode_code(st_r);
               st_nxt.rdata[CPU_RUN_BIT]   = (st_r.mode == M_RUN);
            end
            default: st_nxt.rdata = '0;
         endcase
      end

      // Only software writes move the control bits; no switch or wake
      // path touches them.
      if (bus_take && avs_write_in && avs_byteenable_in[0]) begin
         case (avs_address_in)
            REG_CTRL: begin
               st_nxt.idle_on_sleep   = avs_writedata_in[IDLE_BIT];
               st_nxt.clock_select_hi = avs_writedata_in[SEL_HI_BIT];
               st_nxt.clock_select_lo = avs_writedata_in[SEL_LO_BIT];
               st_nxt.low_freq_source_select = avs_writedata_in[LFSS_BIT];
               st_nxt.internal_freq_select =
                  avs_writedata_in[FREQ_LSB +: FREQ_W];
            end
            REG_CONFIG: begin
               st_nxt.secondary_osc_enable = avs_writedata_in[SEC_EN_BIT];
               st_nxt.wdt_en       = avs_writedata_in[WDT_EN_BIT];
               st_nxt.fail_mon_en  = avs_writedata_in[FAIL_MON_BIT];
               st_nxt.two_speed_en = avs_writedata_in[TWO_SPD_BIT];
            end
            default: begin
               st_nxt.wdt_en = st_r.wdt_en;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_r                        <= '0;
         st_r.mode                   <= M_WAKE;
         st_r.src                    <= SRC_NONE;
         st_r.idle_on_sleep          <= CTRL_RESET[IDLE_BIT];
         st_r.clock_select_hi        <= CTRL_RESET[SEL_HI_BIT];
         st_r.clock_select_lo        <= CTRL_RESET[SEL_LO_BIT];
         st_r.low_freq_source_select <= CTRL_RESET[LFSS_BIT];
         st_r.internal_freq_select   <= CTRL_RESET[FREQ_LSB +: FREQ_W];
         st_r.secondary_osc_enable   <= CONFIG_RESET[SEC_EN_BIT];
         st_r.wdt_en                 <= CONFIG_RESET[WDT_EN_BIT];
         st_r.fail_mon_en            <= CONFIG_RESET[FAIL_MON_BIT];
         st_r.two_speed_en           <= CONFIG_RESET[TWO_SPD_BIT];
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign avs_readdata_out    = st_r.rdata;
   assign avs_waitrequest_out = bus_req && !st_r.ack;

   // CPU clock is gated off in Sleep, Idle and while it gets ready.
   assign cpu_clk_en_out = (st_r.mode == M_RUN);

   // Peripherals run in Run, Idle and the ready delay, but only once
   // the chosen source really oscillates.
   assign periph_clk_en_out = (st_r.mode == M_RUN || st_r.mode == M_IDLE ||
                               st_r.mode == M_READY) &&
                              src_ok(st_r, st_r.src, pri_ready,
                                     sec_running);

   assign clock_mux_sel_out = mux_code(st_r.src);
   assign internal_freq_out = st_r.internal_freq_select;

   assign primary_osc_en_out = (st_r.mode != M_SLEEP) &&
                               (st_r.src == SRC_PRI ||
                                target == SRC_PRI);

   assign secondary_osc_en_out = st_r.secondary_osc_enable;

   assign fast_internal_osc_en_out = fast_req &&
                                     (st_r.mode != M_SLEEP);

   assign slow_internal_rc_en_out = st_r.wdt_en || st_r.fail_mon_en ||
                                    (st_r.mode != M_SLEEP &&
                                     st_r.src == SRC_INT &&
                                     !fast_req);

   assign wdt_reset_out = st_r.wdt_rst;

endmodule // power_mode_clock_sequencer
`default_nettype wire

// ### verification/seq_properties.sv
/* Port assertions for the clock sequencer.
   Assumes a bind to the sequencer's ports. */
`timescale 1ns/1ps
`default_nettype none
module seq_checker
   import power_mode_pkg::*;
(
   input wire logic        clk_in,               // Clock
   input wire logic        arst_n_in,            // Reset
   input wire logic [3:0]  avs_address_in,       // Address
   input wire logic        avs_read_in,          // Read
   input wire logic        avs_write_in,         // Write
   input wire logic [31:0] avs_writedata_in,     // Data
   input wire logic [3:0]  avs_byteenable_in,    // Lanes
   input wire logic        avs_waitrequest_out,  // Stall
   input wire logic        sleep_exec_in,        // Sleep
   input wire logic        wake_irq_in,          // Interrupt
   input wire logic        wdt_timeout_in,       // Watchdog
   input wire logic        cpu_clk_en_out,       // CPU gate
   input wire logic        periph_clk_en_out,    // Peripheral gate
   input wire logic [1:0]  clock_mux_sel_out,    // Source
   input wire logic [2:0]  internal_freq_out,    // Divider
   input wire logic        secondary_osc_en_out, // Secondary on
   input wire logic        wdt_reset_out         // Watchdog reset
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   sequence idle_wake;
      (wake_irq_in || wdt_timeout_in) && !cpu_clk_en_out && periph_clk_en_out;
   endsequence
   sequence cpu_back;
      ##80 !cpu_clk_en_out ##1 cpu_clk_en_out;
   endsequence
   a_one_wait_state: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out) else $error("long stall");
   a_no_idle_stall: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
      else $error("idle stall");
   a_freq_at_once: assert property (
      avs_write_in && !avs_waitrequest_out && avs_address_in == REG_CTRL && avs_byteenable_in[0]
      |=> internal_freq_out == $past(avs_writedata_in[6:4])) else $error("freq late");
   a_sleep_stops_cpu: assert property (
      sleep_exec_in && cpu_clk_en_out && secondary_osc_en_out |=> !cpu_clk_en_out)
      else $error("cpu not stopped");
   a_idle_wake_delay: assert property (idle_wake |-> cpu_back)
      else $error("ready delay");
   a_wdt_run_reset: assert property (wdt_timeout_in && cpu_clk_en_out |=> wdt_reset_out)
      else $error("no wdt reset");
   a_wdt_wakes_only: assert property (wdt_timeout_in && !cpu_clk_en_out |=> !wdt_reset_out)
      else $error("wdt reset in idle");
   a_none_no_clock: assert property (clock_mux_sel_out == 2'h3
      |-> !cpu_clk_en_out && !periph_clk_en_out) else $error("unsourced clock");
   a_sec_needs_en: assert property (clock_mux_sel_out == 2'h1 |-> secondary_osc_en_out)
      else $error("sec disabled");
   a_cpu_with_periph: assert property (cpu_clk_en_out |-> periph_clk_en_out)
      else $error("cpu alone");
endmodule // seq_checker
bind power_mode_clock_sequencer seq_checker i_seq_checker (.clk_in, .arst_n_in,
   .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
   .avs_waitrequest_out, .sleep_exec_in, .wake_irq_in, .wdt_timeout_in, .cpu_clk_en_out,
   .periph_clk_en_out, .clock_mux_sel_out, .internal_freq_out, .secondary_osc_en_out,
   .wdt_reset_out);
`default_nettype wire

// ### verification/osc_model.sv
/* Oscillator pins seen by the sequencer: each reports ready a fixed
   time after it is powered. Assumes one shared clock. */
`timescale 1ns/1ps
`default_nettype none
module osc_model #(
   parameter int PRI_DLY = 20, // Primary start-up, cycles
   parameter int SEC_DLY = 10  // Secondary start-up, cycles
) (
   input  wire logic clk_in,      // Clock
   input  wire logic pri_en_in,   // Primary powered
   input  wire logic sec_en_in,   // Secondary powered
   output logic      pri_rdy_out, // Primary ready
   output logic      secondary_run_mode_out  // Secondary running
);
   int pri_cnt = 0;
   int sec_cnt = 0;
   // Power loss restarts start-up, so no stale ready survives.
   always @(posedge clk_in) begin
      pri_cnt <= pri_en_in ? pri_cnt + (pri_cnt < PRI_DLY) : 0;
      sec_cnt <= sec_en_in ? sec_cnt + (sec_cnt < SEC_DLY) : 0;
   end
   assign pri_rdy_out = (pri_cnt >= PRI_DLY);
   assign secondary_run_mode_out = (sec_cnt >= SEC_DLY);
endmodule // osc_model
`default_nettype wire

// ### verification/tb_top.sv
/* Self-checking bench for the power-mode clock sequencer.
   Assumes the oscillator model and the bound checker beside it. */
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import power_mode_pkg::*;
;
   logic        clk_in = 1'b0, arst_n_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
   logic        sleep_exec_in = 1'b0, wake_irq_in = 1'b0, wdt_timeout_in = 1'b0;
   logic [3:0]  avs_address_in = 4'h0, avs_byteenable_in = 4'hf, be = 4'hf;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd;
   logic        avs_waitrequest_out, cpu_clk_en_out, periph_clk_en_out, wdt_reset_out;
   logic        primary_ready_in, secondary_running_in, primary_osc_en_out, secondary_osc_en_out;
   logic        fast_internal_osc_en_out, slow_internal_rc_en_out;
   logic [1:0]  clock_mux_sel_out;
   logic [2:0]  internal_freq_out;
   int          mismatches = 0, checks_done = 0;
   always #12.5 clk_in = ~clk_in;
   power_mode_clock_sequencer i_power_mode_clock_sequencer (.*);
   osc_model i_osc_model (.clk_in(clk_in), .pri_en_in(primary_osc_en_out),
      .sec_en_in(secondary_osc_en_out), .pri_rdy_out(primary_ready_in),
      .secondary_run_mode_out(secondary_running_in));
   task test_done;
      if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task hang;
      mismatches++;
      $display("Error at %0t: wait ran out", $time);
      test_done();
   endtask
   task bus(input logic we, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_byteenable_in <= be;
      avs_write_in <= we;
      avs_read_in <= !we;
      do begin
         @(posedge clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 20);
      rd = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      if (avs_waitrequest_out !== 1'b0) hang();
      @(negedge clk_in);
   endtask
   task wfor(input logic c, input logic [1:0] m);
      int n;
      n = 0;
      do begin
         @(negedge clk_in);
         n++;
      end while ((cpu_clk_en_out !== c || clock_mux_sel_out !== m) && n < 2000);
      if (n >= 2000) hang();
   endtask
   task pulse(input int k);
      @(posedge clk_in);
      sleep_exec_in <= (k == 0);
      wake_irq_in <= (k == 1);
      wdt_timeout_in <= (k == 2);
      @(posedge clk_in);
      sleep_exec_in <= 1'b0;
      wake_irq_in <= 1'b0;
      wdt_timeout_in <= 1'b0;
      @(negedge clk_in);
   endtask
   function automatic logic [31:0] sw(logic c, logic [2:0] m, logic s, logic i, logic p);
      return {24'h0, c, m, 1'b0, s, i, p};
   endfunction
   task st(input logic [31:0] e);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(rd, e);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task t_boot_regs;
      wfor(1'b1, 2'h0);
      st(sw(1, CODE_PRIMARY_RUN_MODE, 0, 0, 1));
      pulse(2);
      bus(1'b0, REG_CONFIG, 32'h0);
      chk(rd, 32'h0);
      be = 4'he;
      bus(1'b1, REG_CTRL, 32'h80);
      be = 4'hf;
      bus(1'b0, REG_CTRL, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, REG_STATUS, 32'hff);
      st(sw(1, CODE_PRIMARY_RUN_MODE, 0, 0, 1));
      bus(1'b1, 4'hc, 32'hff);
      bus(1'b0, 4'hc, 32'h0);
      chk(rd, 32'h0);
   endtask
   task t_internal;
      bus(1'b1, REG_CTRL, 32'hffff_ff03);
      wfor(1'b1, 2'h2);
      chk(32'({primary_osc_en_out, fast_internal_osc_en_out}), 32'h0);
      st(sw(1, CODE_INT_RUN, 0, 0, 0));
      bus(1'b1, REG_CTRL, 32'h53);
      chk(32'({fast_internal_osc_en_out, internal_freq_out}), 32'hd);
      st(sw(1, CODE_INT_RUN, 0, 0, 0));
      repeat (SETTLE_CYC) @(posedge clk_in);
      st(sw(1, CODE_INT_RUN, 0, 1, 0));
      bus(1'b1, REG_CTRL, 32'h63);
      st(sw(1, CODE_INT_RUN, 0, 1, 0));
      bus(1'b1, REG_CONFIG, 32'h2);
      bus(1'b1, REG_CTRL, 32'h60);
      wfor(1'b1, 2'h0);
      st(sw(1, CODE_PRIMARY_RUN_MODE, 0, 0, 1));
      chk(32'(slow_internal_rc_en_out), 32'h1);
      bus(1'b0, REG_CTRL, 32'h0);
      chk(rd, 32'h60);
   endtask
   task t_primary_idle_mode;
      bus(1'b1, REG_CTRL, 32'h80);
      pulse(0);
      chk(32'({cpu_clk_en_out, periph_clk_en_out}), 32'h1);
      st(sw(0, CODE_PRIMARY_IDLE_MODE, 0, 0, 1));
      pulse(1);
      wfor(1'b1, 2'h0);
      st(sw(1, CODE_PRIMARY_RUN_MODE, 0, 0, 1));
      bus(1'b0, REG_CTRL, 32'h0);
      chk(rd, 32'h80);
   endtask
   task t_secondary;
      bus(1'b1, REG_CTRL, 32'h81);
      pulse(0);
      st(sw(1, CODE_PRIMARY_RUN_MODE, 0, 0, 1));
      bus(1'b1, REG_CONFIG, 32'h3);
      wfor(1'b1, 2'h1);
      pulse(0);
      st(sw(0, CODE_SECONDARY_IDLE_MODE, 1, 0, 0));
      chk(32'(primary_osc_en_out), 32'h0);
      pulse(2);
      wfor(1'b1, 2'h1);
      chk(32'({secondary_osc_en_out, wdt_reset_out}), 32'h2);
   endtask
   task t_sleep;
      bus(1'b1, REG_CTRL, 32'h0);
      wfor(1'b1, 2'h0);
      pulse(0);
      st(sw(0, CODE_SLEEP, 0, 0, 0));
      chk(32'({periph_clk_en_out, primary_osc_en_out, secondary_osc_en_out,
               slow_internal_rc_en_out}), 32'h3);
      pulse(1);
      wfor(1'b1, 2'h0);
      st(sw(1, CODE_PRIMARY_RUN_MODE, 0, 0, 1));
      bus(1'b0, REG_CTRL, 32'h0);
      chk(rd, 32'h0);
   endtask
   initial begin
      repeat (2) @(posedge clk_in);
      arst_n_in <= 1'b1;
      t_boot_regs();
      t_internal();
      t_primary_idle_mode();
      t_secondary();
      t_sleep();
      test_done();
   end
endmodule // tb_top
`default_nettype wire
